/* File: rtl/conn_high_mem.sv */
/*
  Connection word store: one high and one low word per output channel,
  with registered read data.
  Assumes the writer and the single reader share the core clock.
*/
module conn_high_mem #(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic core_clk_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [15:0] wr_data_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic [15:0] rd_data_out
);

  logic [15:0] mem [DEPTH];

  always_ff @(posedge core_clk_in)
  begin
    if (wr_en_in)
    begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  // Power-up contents are unknown; the global enable must keep the serial stream output off.
  always_ff @(posedge core_clk_in)
  begin
    rd_data_out <= mem[rd_addr_in];
  end

endmodule

/* File: rtl/tdm_switch_config_and_connection_map.sv */
/*
  Mode, stream pair and per-channel connection decode of a time-slot switch.
  Assumes a host on an 8-bit port with a one-cycle write strobe and that the
  serial timing logic supplies the output channel index each cycle.
*/
module tdm_switch_config_and_connection_map #(
  parameter int CHANNELS = 256,
  parameter int CW = 8
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic reg_wr_in,
  input wire logic [1:0] reg_sel_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] mode_rdata_out,
  output logic [7:0] pair_rdata_out,
  input wire logic conn_wr_in,
  input wire logic [CW-1:0] conn_addr_in,
  input wire logic [15:0] conn_wdata_in,
  input wire logic [3:0] section_select_bits_in,
  input wire logic [7:0] host_addr_in,
  input wire logic [CW-1:0] out_chan_in,
  input wire logic [7:0] switched_data_in,
  input wire logic global_drive_enable_in,
  output logic [1:0] in_rate_out,
  output logic [1:0] out_rate_out,
  output logic clk_is_bit_rate_out,
  output tsi_pkg::switch_cfg_t cfg_out,
  output tsi_pkg::source_sel_t source_out,
  output logic constant_delay_out,
  output logic [7:0] serial_output_stream_out,
  output logic serial_output_stream_oe_out,
  output logic serial_control_output_out,
  output logic serial_control_output_oe_out,
  output logic pair_active_out,
  output logic [3:0] pair_a_stream_out,
  output logic [3:0] pair_b_stream_out,
  output logic [3:0] dm_section_out,
  output logic [3:0] cm_section_out,
  output logic [6:0] dm_pos_out,
  output logic [6:0] cm_pos_out
);

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  tsi_pkg::mode_reg_t mode;
  logic [7:0] pair_reg;
  logic [15:0] word;
  tsi_pkg::conn_high_t hi;
  tsi_pkg::conn_low_t lo;

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      mode <= tsi_pkg::MODE_RESET;
    end
    else if (reg_wr_in && reg_sel_in == tsi_pkg::SEL_MODE)
    begin
      mode <= reg_wdata_in;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pair_reg <= tsi_pkg::PAIR_RESET;
    end
    else if (reg_wr_in && reg_sel_in == tsi_pkg::SEL_PAIR)
    begin
      pair_reg <= reg_wdata_in;
    end
  end

  assign mode_rdata_out = mode;
  assign pair_rdata_out = pair_reg;

  conn_high_mem #(
    .DEPTH(CHANNELS),
    .AW(CW)
  ) u_mem (
    .core_clk_in(core_clk_in),
    .wr_en_in(conn_wr_in),
    .wr_addr_in(conn_addr_in),
    .wr_data_in(conn_wdata_in),
    .rd_addr_in(out_chan_in),
    .rd_data_out(word)
  );

  assign hi = word[15:8];
  assign lo = word[7:0];

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  function automatic logic [2:0] cbits(input logic [1:0] rate);
    // Channel address width for a rate; reserved treated as narrowest.
    unique case (rate)
      tsi_pkg::RATE_4M: cbits = 3'h6;
      tsi_pkg::RATE_8M: cbits = 3'h7;
      default: cbits = 3'h5;
    endcase
  endfunction

  tsi_pkg::switch_cfg_t next_cfg;
  logic [1:0] ir;
  logic [1:0] orate;
  logic conv;

  assign ir = mode.input_rate_field;
  assign conv = mode.rate_mode_bit;
  assign orate = conv ? mode.output_rate_field : mode.input_rate_field;

  always_comb
  begin
    next_cfg = tsi_pkg::SW_RSV;
    if (conv)
    begin
      next_cfg = tsi_pkg::SW_CONV;
    end
    else
    begin
      unique case (ir)
        tsi_pkg::RATE_2M:
        begin
          unique case (mode.switch_config_field)
            tsi_pkg::CFG_8X8: next_cfg = tsi_pkg::SW_8X8_NB;
            tsi_pkg::CFG_16X8: next_cfg = tsi_pkg::SW_16X8_B;
            tsi_pkg::CFG_PAIR: next_cfg = tsi_pkg::SW_PAIR_NB;
            tsi_pkg::CFG_NIBBLE: next_cfg = tsi_pkg::SW_NIB_8X4;
          endcase
        end
        tsi_pkg::RATE_4M:
        begin
          unique case (mode.switch_config_field)
            tsi_pkg::CFG_8X8: next_cfg = tsi_pkg::SW_8X4_B;
            tsi_pkg::CFG_16X8: next_cfg = tsi_pkg::SW_4X4_NB;
            tsi_pkg::CFG_PAIR: next_cfg = tsi_pkg::SW_RSV;
            tsi_pkg::CFG_NIBBLE: next_cfg = tsi_pkg::SW_RSV;
          endcase
        end
        tsi_pkg::RATE_8M: next_cfg = tsi_pkg::SW_2X2_NB;
        tsi_pkg::RATE_RSV: next_cfg = tsi_pkg::SW_RSV;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cfg_out <= tsi_pkg::SW_8X8_NB;
      in_rate_out <= tsi_pkg::RATE_2M;
      out_rate_out <= tsi_pkg::RATE_2M;
      clk_is_bit_rate_out <= 1'b0;
    end
    else
    begin
      cfg_out <= next_cfg;
      in_rate_out <= ir;
      out_rate_out <= orate;
      clk_is_bit_rate_out <= ~conv & mode.clock_ratio_bit;
    end
  end

  // ----------------------------------------------------------------------
  // Stream pair selection
  // ----------------------------------------------------------------------
  logic pair_on;
  assign pair_on = next_cfg == tsi_pkg::SW_PAIR_NB;

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pair_active_out <= 1'b0;
      pair_a_stream_out <= 4'h0;
      pair_b_stream_out <= 4'h0;
    end
    else
    begin
      pair_active_out <= pair_on;
      pair_a_stream_out <= pair_on ? tsi_pkg::PAIR_BASE
                           + {1'b0, pair_reg[5:3]} : 4'h0;
      pair_b_stream_out <= pair_on ? tsi_pkg::PAIR_BASE
                           + {1'b0, pair_reg[2:0]} : 4'h0;
    end
  end

  // ----------------------------------------------------------------------
  // Source selection from the connection words
  // ----------------------------------------------------------------------
  logic [3:0] full_stream;
  logic [6:0] full_chan;
  logic [3:0] smask;
  logic [2:0] nch;

  assign full_stream = {hi.source_stream_upper_bit,
                        lo.source_stream_lower_bits};
  assign full_chan = {hi.source_channel_upper_bits,
                      lo.source_channel_lower_bits};

  always_comb
  begin
    smask = 4'h7;
    nch = cbits(ir);
    unique case (cfg_out)
      tsi_pkg::SW_16X8_B: smask = 4'hF;
      tsi_pkg::SW_4X4_NB: smask = 4'h6;
      tsi_pkg::SW_2X2_NB: smask = 4'h4;
      tsi_pkg::SW_NIB_8X4: nch = 3'h6;
      tsi_pkg::SW_CONV:
      begin
        smask = (in_rate_out == tsi_pkg::RATE_4M) ? 4'h6 :
                (in_rate_out == tsi_pkg::RATE_8M) ? 4'h4 : 4'h7;
      end
      default: smask = 4'h7;
    endcase
  end

  always_comb
  begin
    source_out.stream = full_stream & smask;
    source_out.channel = full_chan & 7'((8'h01 << nch) - 8'h01);
  end

  assign constant_delay_out = hi.delay_mode_bit;

  // ----------------------------------------------------------------------
  // Serial outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      serial_output_stream_out <= 8'h00;
      serial_output_stream_oe_out <= 1'b0;
      serial_control_output_out <= 1'b0;
      serial_control_output_oe_out <= 1'b0;
    end
    else
    begin
      serial_output_stream_out <= hi.message_channel_bit ? lo
                                  : switched_data_in;
      serial_output_stream_oe_out <= global_drive_enable_in
                                     & hi.drive_enable_bit;
      serial_control_output_out <= hi.control_out_bit;
      serial_control_output_oe_out <= ir == tsi_pkg::RATE_2M
                                      && orate == tsi_pkg::RATE_2M;
    end
  end

  // ----------------------------------------------------------------------
  // Host memory section and position decode
  // ----------------------------------------------------------------------
  logic [2:0] dm_width;
  logic [2:0] cm_width;

  function automatic logic [3:0] sec_mask(input logic [1:0] rate);
    // Faster streams have larger subsections, so fewer section bits.
    unique case (rate)
      tsi_pkg::RATE_4M: sec_mask = 4'h3;
      tsi_pkg::RATE_8M: sec_mask = 4'h1;
      default: sec_mask = 4'h7;
    endcase
  endfunction

  always_comb
  begin
    dm_section_out = section_select_bits_in & sec_mask(in_rate_out);
    cm_section_out = section_select_bits_in & sec_mask(out_rate_out);
    dm_width = cbits(in_rate_out);
    cm_width = cbits(out_rate_out);
    unique case (cfg_out)
      tsi_pkg::SW_16X8_B: dm_section_out = section_select_bits_in;
      tsi_pkg::SW_8X4_B: dm_section_out = section_select_bits_in & 4'h7;
      tsi_pkg::SW_NIB_8X4:
      begin
        cm_section_out = section_select_bits_in & 4'h3;
        dm_width = 3'h6;
        cm_width = 3'h6;
      end
      default: dm_width = cbits(in_rate_out);
    endcase
    dm_pos_out = {host_addr_in[7:6], host_addr_in[4:0]}
                 & 7'((8'h01 << dm_width) - 8'h01);
    cm_pos_out = {host_addr_in[7:6], host_addr_in[4:0]}
                 & 7'((8'h01 << cm_width) - 8'h01);
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_global_float: assert property (!global_drive_enable_in
    |=> !serial_output_stream_oe_out)
    else $error("output driven while global enable low");
  a_pair_ignore: assert property (conv |=> !pair_active_out)
    else $error("pair select active in conversion");
  a_eight_meg: assert property (!conv && ir == tsi_pkg::RATE_8M
    |=> cfg_out == tsi_pkg::SW_2X2_NB)
    else $error("8 Mb/s not 2x2");
  a_out_follow: assert property (!conv
    |=> out_rate_out == $past(ir))
    else $error("output rate does not follow input rate");
  a_clk_ignore: assert property (conv |=> !clk_is_bit_rate_out)
    else $error("clock ratio used in conversion");
  a_msg_data: assert property (hi.message_channel_bit
    |=> serial_output_stream_out == $past(lo))
    else $error("message channel not sending low word");
  a_pair_range: assert property (pair_active_out
    |-> pair_a_stream_out >= tsi_pkg::PAIR_BASE)
    else $error("pair stream below two");
  a_two_by_two: assert property (cfg_out == tsi_pkg::SW_2X2_NB
    |-> source_out.stream[1:0] == 2'h0)
    else $error("2x2 uses low stream bits");

endmodule

/* File: rtl/tsi_pkg.sv */
/*
  Constants and carrier types for the switch configuration and connection map.
  Assumes a single 100 MHz core clock and an 8-bit parallel register port.
*/
package tsi_pkg;

  // ----------------------------------------------------------------------
  // Register selects on the parallel port
  // ----------------------------------------------------------------------
  localparam logic [1:0] SEL_MODE = 2'h1;
  localparam logic [1:0] SEL_PAIR = 2'h2;

  // ----------------------------------------------------------------------
  // Rate codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] RATE_2M = 2'h0;
  localparam logic [1:0] RATE_4M = 2'h1;
  localparam logic [1:0] RATE_8M = 2'h2;
  localparam logic [1:0] RATE_RSV = 2'h3;

  localparam logic [1:0] CFG_8X8 = 2'h0;
  localparam logic [1:0] CFG_16X8 = 2'h1;
  localparam logic [1:0] CFG_PAIR = 2'h2;
  localparam logic [1:0] CFG_NIBBLE = 2'h3;

  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] PAIR_RESET = 8'h00;
  localparam logic [7:0] HIGH_RESET = 8'h00;
  localparam logic [3:0] PAIR_BASE = 4'h2;

  // ----------------------------------------------------------------------
  // Decoded switch configuration
  // ----------------------------------------------------------------------
  typedef enum logic [10:0] {
    SW_8X8_NB = 11'h001,
    SW_16X8_B = 11'h002,
    SW_PAIR_NB = 11'h004,
    SW_NIB_8X4 = 11'h008,
    SW_8X4_B = 11'h010,
    SW_4X4_NB = 11'h020,
    SW_2X2_NB = 11'h040,
    SW_CONV = 11'h080,
    SW_RSV = 11'h100
  } switch_cfg_t;

  typedef struct packed {
    logic rate_mode_bit;
    logic [1:0] input_rate_field;
    logic [1:0] output_rate_field;
    logic [1:0] switch_config_field;
    logic clock_ratio_bit;
  } mode_reg_t;

  typedef struct packed {
    logic unused_bit;
    logic delay_mode_bit;
    logic source_stream_upper_bit;
    logic [1:0] source_channel_upper_bits;
    logic message_channel_bit;
    logic control_out_bit;
    logic drive_enable_bit;
  } conn_high_t;

  typedef struct packed {
    logic [2:0] source_stream_lower_bits;
    logic [4:0] source_channel_lower_bits;
  } conn_low_t;

  typedef struct packed {
    logic [3:0] stream;
    logic [6:0] channel;
  } source_sel_t;

endpackage

/* File: tb/host_model.sv */
/*
  Host processor model that writes the mode, stream pair and connection
  words over the parallel port.
  Assumes the bench calls its tasks and that the core clock is shared.
*/
module host_model
(
  input wire logic core_clk_in,
  output logic reg_wr_out,
  output logic [1:0] reg_sel_out,
  output logic [7:0] reg_wdata_out,
  output logic conn_wr_out,
  output logic [7:0] conn_addr_out,
  output logic [15:0] conn_wdata_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------------
  // Port cycles
  // ----------------------------------------------------------------------
  // Released data is inverted so a stale value can never pass for a fresh one.
  initial
  begin
    reg_wr_out = 1'b0;
    reg_sel_out = 2'h0;
    reg_wdata_out = 8'h00;
    conn_wr_out = 1'b0;
    conn_addr_out = 8'h00;
    conn_wdata_out = 16'h0000;
  end

  task automatic write_reg(input logic [1:0] sel, input logic [7:0] data);
    @(posedge core_clk_in);
    #1;
    reg_sel_out = sel;
    reg_wdata_out = data;
    reg_wr_out = 1'b1;
    @(posedge core_clk_in);
    #1;
    reg_wr_out = 1'b0;
    reg_wdata_out = ~data;
  endtask

  task automatic write_conn(input logic [7:0] addr, input logic [15:0] data);
    @(posedge core_clk_in);
    #1;
    conn_addr_out = addr;
    conn_wdata_out = data;
    conn_wr_out = 1'b1;
    @(posedge core_clk_in);
    #1;
    conn_wr_out = 1'b0;
    conn_wdata_out = ~data;
  endtask
endmodule

/* File: tb/tb_top.sv */
/*
  Self-checking bench for the switch configuration and connection map.
  Assumes the host model drives the port and expectations come from here.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic reg_wr, conn_wr, gde, serial_control_output, serial_control_output_oe, so_oe, cdel, pact, clkbr;
  logic [1:0] reg_sel, in_rate, out_rate;
  logic [7:0] reg_wdata, conn_addr, mode_rd, pair_rd, sw_data, so;
  logic [7:0] host_addr, out_chan;
  logic [15:0] conn_wdata;
  logic [3:0] section_select_bits, pa, pb, dm_sec, cm_sec;
  logic [6:0] dm_pos, cm_pos;
  tsi_pkg::switch_cfg_t cfg;
  tsi_pkg::source_sel_t src;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;
  int seed = 99;
  localparam logic [3:0] SMASK [9] = '{7, 15, 6, 7, 4, 7, 7, 6, 4};
  localparam logic [6:0] CMASK [9] = '{31, 31, 63, 63, 127, 31, 31, 63, 127};
  localparam logic [3:0] DMS [9] = '{7, 15, 3, 7, 1, 7, 7, 3, 1};
  localparam logic [3:0] CMS [9] = '{7, 7, 3, 3, 1, 3, 1, 7, 7};
  localparam int DMW [9] = '{5, 5, 6, 6, 7, 5, 5, 6, 7};
  localparam int CMW [9] = '{5, 5, 6, 6, 7, 6, 7, 5, 5};
  localparam logic [7:0] MODES [10] = '{8'h00, 8'h02, 8'h06, 8'h20, 8'h22,
    8'h40, 8'h88, 8'h90, 8'hA0, 8'hC0};

  always #5 core_clk_in = ~core_clk_in;

  host_model i_host (.core_clk_in(core_clk_in), .reg_wr_out(reg_wr),
    .reg_sel_out(reg_sel), .reg_wdata_out(reg_wdata), .conn_wr_out(conn_wr),
    .conn_addr_out(conn_addr), .conn_wdata_out(conn_wdata));

  tdm_switch_config_and_connection_map i_dut (.core_clk_in(core_clk_in),
    .rst_in(rst_in), .reg_wr_in(reg_wr), .reg_sel_in(reg_sel),
    .reg_wdata_in(reg_wdata), .mode_rdata_out(mode_rd),
    .pair_rdata_out(pair_rd), .conn_wr_in(conn_wr), .conn_addr_in(conn_addr),
    .conn_wdata_in(conn_wdata), .section_select_bits_in(section_select_bits),
    .host_addr_in(host_addr), .out_chan_in(out_chan),
    .switched_data_in(sw_data), .global_drive_enable_in(gde),
    .in_rate_out(in_rate), .out_rate_out(out_rate),
    .clk_is_bit_rate_out(clkbr), .cfg_out(cfg), .source_out(src),
    .constant_delay_out(cdel), .serial_output_stream_out(so),
    .serial_output_stream_oe_out(so_oe), .serial_control_output_out(serial_control_output),
    .serial_control_output_oe_out(serial_control_output_oe), .pair_active_out(pact),
    .pair_a_stream_out(pa), .pair_b_stream_out(pb), .dm_section_out(dm_sec),
    .cm_section_out(cm_sec), .dm_pos_out(dm_pos), .cm_pos_out(cm_pos));

  // ----------------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------------
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  always @(posedge core_clk_in)
  begin
    cycles = cycles + 1;
    if (cycles == 5000)
    begin
      err_total = err_total + 1;
      conclude();
    end
  end

  // ----------------------------------------------------------------------
  // Expectations
  // ----------------------------------------------------------------------
  function automatic tsi_pkg::switch_cfg_t cfg_exp(input logic [7:0] m);
    case (m[6:5])
      tsi_pkg::RATE_2M: return m[2:1] == 2'h0 ? tsi_pkg::SW_8X8_NB :
        m[2:1] == 2'h1 ? tsi_pkg::SW_16X8_B :
        m[2:1] == 2'h2 ? tsi_pkg::SW_PAIR_NB : tsi_pkg::SW_NIB_8X4;
      tsi_pkg::RATE_4M: return m[2:1] == 2'h0 ? tsi_pkg::SW_8X4_B :
        m[2:1] == 2'h1 ? tsi_pkg::SW_4X4_NB : tsi_pkg::SW_RSV;
      tsi_pkg::RATE_8M: return tsi_pkg::SW_2X2_NB;
      default: return tsi_pkg::SW_RSV;
    endcase
  endfunction

  // Configuration class indexing the mask tables; 15 means not checked.
  function automatic int cls(input logic [7:0] m);
    if (!m[7])
      case (m[6:3] & 4'hC | {2'h0, m[2:1]})
        4'h0: return 0;
        4'h1: return 1;
        4'h3: return 3;
        4'h4: return 3;
        4'h5: return 2;
        4'h8, 4'h9, 4'hA, 4'hB: return 4;
        default: return 15;
      endcase
    case (m[6:3])
      4'h1: return 5;
      4'h2: return 6;
      4'h4: return 7;
      4'h8: return 8;
      default: return 15;
    endcase
  endfunction

  function automatic logic [6:0] pos(input logic [7:0] a, input int w);
    return w == 5 ? {2'h0, a[4:0]} : w == 6 ? {1'b0, a[6], a[4:0]} :
      {a[7], a[6], a[4:0]};
  endfunction

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial
  begin
    logic [7:0] m;
    logic [7:0] p;
    logic [15:0] w;
    int k;
    logic act;
    logic ctl;
    gde = 1'b0;
    section_select_bits = 4'h0;
    host_addr = 8'h00;
    out_chan = 8'h00;
    sw_data = 8'h00;
    repeat (20) @(posedge core_clk_in);
    #1;
    rst_in = 1'b0;
    check(mode_rd, tsi_pkg::MODE_RESET);
    check(pair_rd, tsi_pkg::PAIR_RESET);
    check(cfg, tsi_pkg::SW_8X8_NB);
    check({so_oe, serial_control_output_oe}, 2'h0);
    // Channel zero is read from power-up, so give it a known word first.
    i_host.write_conn(8'h00, 16'h0000);
    // Every rate and configuration code first, then random mode words.
    for (int i = 0; i < 48; i++)
    begin
      m = i < 16 ? {1'b0, i[3:2], 2'h0, i[1:0], i[0]} : 8'($random(seed));
      p = 8'($random(seed));
      i_host.write_reg(tsi_pkg::SEL_MODE, m);
      i_host.write_reg(tsi_pkg::SEL_PAIR, p);
      i_host.write_reg(2'h0, ~m);
      i_host.write_reg(2'h3, ~p);
      repeat (2) @(posedge core_clk_in);
      #1;
      act = !m[7] && m[2:1] == tsi_pkg::CFG_PAIR && m[6:5] == tsi_pkg::RATE_2M;
      check(mode_rd, m);
      check(pair_rd, p);
      check(in_rate, m[6:5]);
      check(out_rate, m[7] ? m[4:3] : m[6:5]);
      check(pact, act);
      if (!m[7])
      begin
        check(clkbr, m[0]);
        check(cfg, cfg_exp(m));
      end
      if (act)
      begin
        check(pa, tsi_pkg::PAIR_BASE + p[5:3]);
        check(pb, tsi_pkg::PAIR_BASE + p[2:0]);
      end
    end
    // Connection words under the ten listed identical and conversion modes (no pair mode).
    for (int i = 0; i < 40; i++)
    begin
      m = MODES[i < 10 ? i : ($random(seed) & 32'h7FFF) % 10];
      w = 16'($random(seed));
      i_host.write_reg(tsi_pkg::SEL_MODE, m);
      i_host.write_conn(8'(i * 7), w);
      out_chan = 8'(i * 7);
      sw_data = 8'($random(seed));
      gde = i < 4 ? 1'b1 : 1'($random(seed));
      repeat (3) @(posedge core_clk_in);
      #1;
      k = cls(m);
      ctl = m[6:5] == 2'h0 && (!m[7] || m[4:3] == 2'h0);
      check(cdel, w[14]);
      check(so_oe, gde & w[8]);
      if (gde & w[8])
        check(so, w[10] ? w[7:0] : sw_data);
      check(serial_control_output_oe, ctl);
      if (ctl)
        check(serial_control_output, w[9]);
      section_select_bits = 4'($random(seed));
      host_addr = 8'($random(seed));
      #1;
      if (k != 15)
      begin
        check(src, {{w[13], w[7:5]} & SMASK[k],
          {w[12:11], w[4:0]} & CMASK[k]});
        check({dm_sec, dm_pos},
          {section_select_bits & DMS[k], pos(host_addr, DMW[k])});
        check({cm_sec, cm_pos},
          {section_select_bits & CMS[k], pos(host_addr, CMW[k])});
      end
    end
    conclude();
  end
endmodule
